//--- bench/fbm_core_model.sv
// Core-side responder for the ROM and peripheral read ports.
`timescale 1ns/1ps
module fbm_core_model #(
	parameter logic [23:0] ROM_WORD = 24'h5a0f3c,
	parameter logic [15:0] PER_WORD = 16'hc3a5
) (
	// Clock.
	input wire logic sys_clk,
	// Selects from the block.
	input wire logic rom_sel,
	input wire logic periph_sel,
	// Read data back.
	output logic [23:0] rom_rdata,
	output logic [15:0] periph_rdata
);
	// Unselected sources flip every cycle, so a stale read is caught.
	// This side never writes the flash interface registers.
	logic [23:0] rom_last = 24'h000000;
	logic [15:0] per_last = 16'h0000;
	always_ff @(posedge sys_clk) begin
		rom_last <= rom_rdata;
		per_last <= periph_rdata;
	end
	assign rom_rdata = rom_sel ? ROM_WORD : ~rom_last;
	assign periph_rdata = periph_sel ? PER_WORD : ~per_last;
endmodule : fbm_core_model

//--- bench/fbm_properties.sv
// Concurrent checks on the ports of the memory map block.
`timescale 1ns/1ps
module fbm_properties
	import fbm_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Memory buses.
	input wire fbm_pm_req_s pm_req,
	input wire logic [23:0] pm_rdata,
	input wire logic rom_sel,
	input wire logic [23:0] rom_rdata,
	input wire fbm_dm_req_s dm_req,
	input wire logic [15:0] dm_rdata,
	input wire logic periph_sel,
	// Boot and utility side.
	input wire logic fetch_load,
	input wire logic [13:0] fetch_addr,
	input wire logic ext_boot_req,
	input wire fbm_core_init_s core_init,
	input wire fbm_util_req_s util_req,
	input wire logic util_ready,
	input wire logic util_refused
);
	// All checks share one domain and are silent while reset is held.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Read strobes and reserved windows of both spaces.
	wire pm_rd = pm_req.en && !pm_req.we;
	wire dm_rd = dm_req.en && !dm_req.we;
	wire pm_rsv = pm_req.addr inside {[14'h0200:14'h07ff],
		[14'h1800:14'h1fff], [14'h3000:14'h3fff]};
	wire dm_rsv = dm_req.addr inside {[14'h0000:14'h1fff],
		[14'h2100:14'h37ff], [14'h3a00:14'h3bff]};
	wire rom_hit = pm_req.addr inside {[PM_ROM_LO:PM_ROM_HI]};
	wire per_hit = dm_req.addr inside {[14'h2000:14'h207f],
		[14'h3c00:14'h3fff]};
	property p_reset_vec;
		$fell(rst) |-> fetch_addr == ROM_ENTRY && core_init == 3'b111;
	endproperty
	a_reset_vec: assert property (p_reset_vec)
		else $error("reset state wrong");
	property p_rom_sel;
		rom_sel == (pm_rd && rom_hit);
	endproperty
	a_rom_sel: assert property (p_rom_sel)
		else $error("rom select wrong");
	property p_rom_data;
		rom_sel |=> pm_rdata == $past(rom_rdata);
	endproperty
	a_rom_data: assert property (p_rom_data)
		else $error("rom data not returned");
	property p_pm_rsv;
		pm_rd && pm_rsv |=> pm_rdata == 24'h000000;
	endproperty
	a_pm_rsv: assert property (p_pm_rsv)
		else $error("reserved program read not zero");
	property p_dm_rsv;
		dm_rd && dm_rsv |=> dm_rdata == 16'h0000;
	endproperty
	a_dm_rsv: assert property (p_dm_rsv)
		else $error("reserved data read not zero");
	property p_periph;
		dm_req.en && per_hit |-> periph_sel;
	endproperty
	a_periph: assert property (p_periph)
		else $error("peripheral window not selected");
	property p_refuse;
		util_refused |-> $past(util_req.valid && !util_ready);
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("refusal without request");
	property p_boot;
		$fell(rst) |-> ##2 (fetch_load && fetch_addr == APP_ENTRY)
			!= ext_boot_req;
	endproperty
	a_boot: assert property (p_boot)
		else $error("boot choice wrong");
	property p_ext_pulse;
		ext_boot_req |=> !ext_boot_req && !fetch_load;
	endproperty
	a_ext_pulse: assert property (p_ext_pulse)
		else $error("external boot not a pulse");
endmodule : fbm_properties

bind fbm_memory_map fbm_properties fbm_properties_i (.sys_clk, .rst,
	.pm_req, .pm_rdata, .rom_sel, .rom_rdata, .dm_req, .dm_rdata,
	.periph_sel, .fetch_load, .fetch_addr, .ext_boot_req, .core_init,
	.util_req, .util_ready, .util_refused);

//--- bench/testbench.sv
// Self-checking bench for the memory map and boot block.
`timescale 1ns/1ps
module testbench;
	import fbm_pkg::*;
	localparam logic [23:0] ROMV = 24'h5a0f3c;
	localparam logic [15:0] PERV = 16'hc3a5;
	// One access: data space, write, address, data or expected value.
	typedef struct {bit d; bit w; logic [13:0] a; logic [23:0] v;} fbm_row_s;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	fbm_pm_req_s pm_req = '0;
	fbm_dm_req_s dm_req = '0;
	fbm_util_req_s util_req = '0;
	logic clear_secure_req = 1'b0;
	logic clear_keep_req = 1'b0;
	logic [23:0] pm_rdata, rom_rdata, util_rdata, rd;
	logic [15:0] dm_rdata, periph_rdata;
	logic rom_sel, periph_sel, fetch_load, ext_boot_req;
	logic util_ready, util_refused, util_done;
	logic [13:0] fetch_addr;
	fbm_core_init_s core_init;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	fbm_row_s rows [13] = '{'{0, 1, 14'h0030, 24'h123456},
		'{0, 0, 14'h0030, 24'h123456}, '{0, 0, 14'h0800, ROMV},
		'{0, 0, 14'h0200, 24'h0}, '{0, 0, 14'h1800, 24'h0},
		'{0, 0, 14'h3000, 24'h0}, '{1, 1, 14'h3800, 24'hbeef},
		'{1, 0, 14'h3800, 24'hbeef}, '{1, 1, 14'h0100, 24'hffff},
		'{1, 0, 14'h0100, 24'h0}, '{1, 0, 14'h3a00, 24'h0},
		'{1, 0, 14'h3c00, {8'h0, PERV}}, '{1, 0, 14'h2000, {8'h0, PERV}}};
	fbm_memory_map fbm_memory_map_i (.sys_clk, .rst, .pm_req, .pm_rdata,
		.rom_sel, .rom_rdata, .dm_req, .dm_rdata, .periph_sel,
		.periph_rdata, .fetch_load, .fetch_addr, .ext_boot_req, .core_init,
		.clear_secure_req, .clear_keep_req, .util_req, .util_ready,
		.util_refused, .util_done, .util_rdata);
	fbm_core_model #(.ROM_WORD(ROMV), .PER_WORD(PERV)) fbm_core_model_i (
		.sys_clk, .rom_sel, .periph_sel, .rom_rdata, .periph_rdata);
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	// A hang is cut short well past the longest erase.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			stop_test();
		end
	end
	task automatic stop_test();
		if (n_fail == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// One bus cycle; the answer is taken one cycle after the request.
	task automatic acc(input fbm_row_s r);
		@(negedge sys_clk);
		if (r.d) dm_req = '{1'b1, r.w, r.a, r.v[15:0]};
		else pm_req = '{1'b1, r.w, r.a, r.v};
		@(negedge sys_clk);
		pm_req.en = 1'b0;
		dm_req.en = 1'b0;
		rd = r.d ? {8'h0, dm_rdata} : pm_rdata;
	endtask : acc
	// Utility command held until taken, then wait for completion.
	task automatic util(input fbm_op_e op, input logic [11:0] a,
		input logic [23:0] v);
		@(negedge sys_clk);
		util_req = '{1'b1, op, a, v};
		// A hang is left to the watchdog, so it always counts as a failure.
		while (util_ready !== 1'b1) @(negedge sys_clk);
		@(negedge sys_clk);
		util_req.valid = 1'b0;
		while (util_done !== 1'b1) @(negedge sys_clk);
	endtask : util
	initial begin
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		chk(fetch_addr, ROM_ENTRY);
		chk(core_init, 3'b111);
		repeat (2) @(negedge sys_clk);
		chk(ext_boot_req, 1'b1);
		foreach (rows[i]) begin
			acc(rows[i]);
			if (!rows[i].w) chk(rd, rows[i].v);
		end
		util(OP_PROGRAM, 12'h205, 24'habcdef);
		util(OP_PROGRAM, 12'h0ff, 24'h111111);
		util(OP_PROGRAM, 12'h100, 24'h222222);
		util(OP_ERASE_SECTOR, 12'h000, 24'h0);
		util(OP_READ, 12'h100, 24'h0);
		chk(util_rdata, 24'h222222);
		// The core only reads the interface registers, never writes them.
		acc('{1, 0, REG_FLASH_ADDR, 24'h0});
		chk(rd, 24'h000100);
		acc('{1, 0, REG_FLASH_DLO, 24'h0});
		chk(rd, 24'h002222);
		acc('{1, 0, REG_FLASH_DHI, 24'h0});
		chk(rd, 24'h000022);
		acc('{1, 0, REG_FLASH_CTRL, 24'h0});
		chk(rd, 24'h1 << CTL_DONE);
		acc('{0, 0, 14'h20ff, 24'h0});
		chk(rd, FLASH_ERASED);
		acc('{0, 0, 14'h2205, 24'h0});
		chk(rd, 24'habcdef);
		util(OP_NVB_WRITE, 12'h003, 24'h00005a);
		util(OP_NVB_READ, 12'h003, 24'h0);
		chk(util_rdata[7:0], 8'h5a);
		util(OP_NVB_ERASE, 12'h000, 24'h0);
		util(OP_NVB_READ, 12'h003, 24'h0);
		chk(util_rdata[7:0], NVB_ERASED);
		util(OP_PROGRAM, 12'h200, 24'h0c0de1);
		util(OP_SET_BOOT, 12'h000, 24'h0);
		@(negedge sys_clk);
		util_req.valid = 1'b1;
		chk(util_ready, 1'b0);
		@(negedge sys_clk);
		util_req.valid = 1'b0;
		chk(util_refused, 1'b1);
		rst = 1'b1;
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk({fetch_load, fetch_addr}, {1'b1, APP_ENTRY});
		clear_keep_req = 1'b1;
		@(negedge sys_clk);
		clear_keep_req = 1'b0;
		util(OP_READ, 12'h200, 24'h0);
		chk(util_rdata, 24'h0c0de1);
		util(OP_SET_BOOT, 12'h000, 24'h0);
		@(negedge sys_clk);
		clear_secure_req = 1'b1;
		@(negedge sys_clk);
		clear_secure_req = 1'b0;
		util(OP_READ, 12'h205, 24'h0);
		chk(util_rdata, FLASH_ERASED);
		stop_test();
	end
endmodule : testbench

//--- hdl/fbm_flash_array.sv
// Nonvolatile 24-bit flash array with one write and two read ports.
`timescale 1ns/1ps
module fbm_flash_array
	import fbm_pkg::*;
#(
	parameter int WORDS = FLASH_WORDS,
	parameter int WIDTH = FLASH_W,
	parameter int AW = FLASH_AW
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Write port.
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// Read port A, used by instruction fetch.
	input wire logic [AW-1:0] rda_addr,
	output logic [WIDTH-1:0] rda_data,
	// Read port B, used by the flash engine.
	input wire logic [AW-1:0] rdb_addr,
	output logic [WIDTH-1:0] rdb_data
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// The cells are nonvolatile, so reset never touches them.
	logic [WIDTH-1:0] cells [WORDS];

	// Writes land in the cell addressed; erase is a walk of writes.
	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			cells[wr_addr] <= wr_data;
		end
	end

	// Both read ports are registered; the outputs reset to zero.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rda_data <= '0;
			rdb_data <= '0;
		end else begin
			rda_data <= cells[rda_addr];
			rdb_data <= cells[rdb_addr];
		end
	end

endmodule : fbm_flash_array

//--- hdl/fbm_memory_map.sv
// Memory map decoder, flash engine and boot sequencer of the core.
`timescale 1ns/1ps
module fbm_memory_map
	import fbm_pkg::*;
#(
	parameter int RAM_DEPTH = RAM_WORDS,
	parameter int NVB_N = NVB_COUNT
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Program memory bus.
	input wire fbm_pm_req_s pm_req,
	output logic [23:0] pm_rdata,
	output logic rom_sel,
	input wire logic [23:0] rom_rdata,
	// Data memory bus.
	input wire fbm_dm_req_s dm_req,
	output logic [15:0] dm_rdata,
	output logic periph_sel,
	input wire logic [15:0] periph_rdata,
	// Boot sequence toward the core.
	output logic fetch_load,
	output logic [13:0] fetch_addr,
	output logic ext_boot_req,
	output fbm_core_init_s core_init,
	// ROM routines called by the running application.
	input wire logic clear_secure_req,
	input wire logic clear_keep_req,
	// External programming utility and debugger.
	input wire fbm_util_req_s util_req,
	output logic util_ready,
	output logic util_refused,
	output logic util_done,
	output logic [23:0] util_rdata
);

	// ----------------------------------------------------------------
	// Program space decode
	// ----------------------------------------------------------------
	wire pm_in_ram = pm_req.addr <= PM_RAM_HI;
	wire pm_in_vec = pm_req.addr <= PM_VEC_HI;
	wire pm_in_rom = (pm_req.addr >= PM_ROM_LO)
		&& (pm_req.addr <= PM_ROM_HI);
	wire pm_in_flash = (pm_req.addr >= PM_FL_LO)
		&& (pm_req.addr <= PM_FL_HI);
	// Flash index; sectors follow one another from PM_FL_LO.
	wire [13:0] pm_fl_off = pm_req.addr - PM_FL_LO;
	wire [11:0] pm_fl_idx = pm_fl_off[11:0];
	wire [8:0] pm_ram_idx = pm_req.addr[8:0];
	// Vector table is part of RAM; kept visible for clarity.
	wire pm_ram_hit = pm_req.en && (pm_in_ram || pm_in_vec);
	wire pm_ram_wr = pm_ram_hit && pm_req.we;
	// ROM is read-only; a write there is dropped.
	assign rom_sel = pm_req.en && pm_in_rom && !pm_req.we;

	// ----------------------------------------------------------------
	// Data space decode
	// ----------------------------------------------------------------
	wire dm_in_ram = (dm_req.addr >= DM_RAM_LO)
		&& (dm_req.addr <= DM_RAM_HI);
	wire dm_in_per0 = (dm_req.addr >= DM_PER0_LO)
		&& (dm_req.addr <= DM_PER0_HI);
	wire dm_in_per1 = dm_req.addr >= DM_PER1_LO;
	wire dm_is_ctrl = dm_req.addr == REG_FLASH_CTRL;
	wire dm_is_addr = dm_req.addr == REG_FLASH_ADDR;
	wire dm_is_dlo = dm_req.addr == REG_FLASH_DLO;
	wire dm_is_dhi = dm_req.addr == REG_FLASH_DHI;
	wire dm_is_freg = dm_is_ctrl || dm_is_addr || dm_is_dlo
		|| dm_is_dhi;
	wire [8:0] dm_ram_idx = dm_req.addr[8:0];
	wire dm_wr = dm_req.en && dm_req.we;
	wire dm_ram_wr = dm_wr && dm_in_ram;
	// Other register addresses go to the peripherals outside.
	assign periph_sel = dm_req.en && (dm_in_per0 || dm_in_per1)
		&& !dm_is_freg;

	// ----------------------------------------------------------------
	// Engine state and command selection
	// ----------------------------------------------------------------
	// Idle, one-cycle execute, read wait, erase walk.
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_EXEC = 4'b0010,
		ST_READ = 4'b0100,
		ST_WALK = 4'b1000
	} fbm_eng_e;

	fbm_eng_e eng_r; // Engine state.
	fbm_eng_e eng_nxt; // Next engine state.
	fbm_op_e op_r; // Operation in progress.
	logic from_util_r; // Operation came from the outside utility.
	logic clear_after_r; // Clear boot code when the walk ends.
	logic [11:0] walk_r; // Current erase index.
	logic [11:0] walk_last_r; // Last index of the erase walk.
	logic boot_code_r = 1'b0; // Nonvolatile boot-from-flash code.
	logic done_r; // Sticky completion flag.
	logic [11:0] flash_addr_r; // Address register.
	logic [15:0] flash_dlo_r; // Data low register.
	logic [7:0] flash_dhi_r; // Data high register, low bits.
	logic [NVB_W-1:0] nvb [NVB_N]; // Nonvolatile byte registers.
	logic [23:0] flash_rdb; // Engine read data from the array.
	logic [23:0] flash_rda; // Fetch read data from the array.

	wire idle = eng_r == ST_IDLE;
	// A control write with the go bit starts an engine command.
	wire core_go = idle && dm_wr && dm_is_ctrl && dm_req.wdata[CTL_GO];
	// The application's ROM routines take precedence after the core.
	wire sec_go = idle && !core_go && clear_secure_req;
	wire keep_go = idle && !core_go && !sec_go
		&& clear_keep_req;
	// Utility is served only when nothing else wants the engine.
	assign util_ready = idle && !boot_code_r && !core_go
		&& !clear_secure_req && !clear_keep_req;
	wire util_go = util_req.valid && util_ready;
	wire cmd_go = core_go || util_go;
	wire fbm_op_e cmd_op = core_go
		? fbm_op_e'(dm_req.wdata[CTL_OP_LSB +: 3]) : util_req.op;
	wire [11:0] cmd_addr = core_go ? flash_addr_r : util_req.addr;
	wire [23:0] cmd_data = core_go ? {flash_dhi_r, flash_dlo_r}
		: util_req.data;
	// Sector bounds of the addressed word.
	wire [11:0] sec_lo = (cmd_addr < SEC1_IDX) ? 12'h000
		: (cmd_addr < SEC2_IDX) ? SEC1_IDX : SEC2_IDX;
	wire [11:0] sec_hi = (cmd_addr < SEC1_IDX) ? SEC0_LAST
		: (cmd_addr < SEC2_IDX) ? SEC1_LAST : SEC2_LAST;
	wire cmd_walk = cmd_op == OP_ERASE_SECTOR || cmd_op == OP_ERASE_ALL;
	wire walk_end = (eng_r == ST_WALK) && (walk_r == walk_last_r);
	wire finish = walk_end || (eng_r == ST_READ)
		|| ((eng_r == ST_EXEC) && op_r != OP_READ);

	// Array write port: program or erase-walk.
	wire arr_prog = (eng_r == ST_EXEC) && op_r == OP_PROGRAM;
	wire arr_wr = arr_prog || (eng_r == ST_WALK);
	wire [11:0] arr_waddr = arr_prog ? flash_addr_r : walk_r;
	wire [23:0] arr_wdata = arr_prog ? {flash_dhi_r, flash_dlo_r}
		: FLASH_ERASED;

	// ----------------------------------------------------------------
	// Flash array
	// ----------------------------------------------------------------
	fbm_flash_array #(
		.WORDS(FLASH_WORDS),
		.WIDTH(FLASH_W),
		.AW(FLASH_AW)
	) u_array (
		.sys_clk(sys_clk),
		.rst(rst),
		.wr_en(arr_wr),
		.wr_addr(arr_waddr),
		.wr_data(arr_wdata),
		.rda_addr(pm_fl_idx),
		.rda_data(flash_rda),
		.rdb_addr(flash_addr_r),
		.rdb_data(flash_rdb)
	);

	// ----------------------------------------------------------------
	// Engine sequencing
	// ----------------------------------------------------------------
	// Next state: single-word ops take one cycle, reads two.
	always_comb begin
		eng_nxt = eng_r;
		unique case (eng_r)
			ST_IDLE: begin
				if (cmd_go && cmd_walk) begin
					eng_nxt = ST_WALK;
				end else if (cmd_go) begin
					eng_nxt = ST_EXEC;
				end else if (sec_go) begin
					eng_nxt = ST_WALK;
				end
			end
			ST_EXEC: begin
				eng_nxt = (op_r == OP_READ) ? ST_READ : ST_IDLE;
			end
			ST_READ: begin
				eng_nxt = ST_IDLE;
			end
			ST_WALK: begin
				if (walk_end) begin
					eng_nxt = ST_IDLE;
				end
			end
		endcase
	end

	// State, operation latch and erase walk bounds.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			eng_r <= ST_IDLE;
			op_r <= OP_READ;
			from_util_r <= 1'b0;
			clear_after_r <= 1'b0;
			walk_r <= '0;
			walk_last_r <= '0;
		end else begin
			eng_r <= eng_nxt;
			if (cmd_go) begin
				op_r <= cmd_op;
				from_util_r <= util_go;
				clear_after_r <= 1'b0;
				walk_r <= (cmd_op == OP_ERASE_ALL) ? 12'h000 : sec_lo;
				walk_last_r <= (cmd_op == OP_ERASE_ALL) ? SEC2_LAST
					: sec_hi;
			end else if (sec_go) begin
				// Whole program is erased before the code clears.
				op_r <= OP_ERASE_ALL;
				from_util_r <= 1'b0;
				clear_after_r <= 1'b1;
				walk_r <= 12'h000;
				walk_last_r <= SEC2_LAST;
			end else if (eng_r == ST_WALK) begin
				walk_r <= walk_r + 12'h001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Boot-from-flash code
	// ----------------------------------------------------------------
	// Nonvolatile: no reset; powers up clear in this model. Only the
	// outside utility may set it, and only the application's ROM
	// routines clear it.
	always_ff @(posedge sys_clk) begin
		if (walk_end && clear_after_r) begin
			boot_code_r <= 1'b0;
		end else if (keep_go) begin
			boot_code_r <= 1'b0;
		end else if ((eng_r == ST_EXEC) && op_r == OP_SET_BOOT
			&& from_util_r) begin
			boot_code_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Nonvolatile byte registers
	// ----------------------------------------------------------------
	// Stored apart from the main array; reset leaves them alone.
	genvar gi;
	generate
		for (gi = 0; gi < NVB_N; gi++) begin : g_nvb
			always_ff @(posedge sys_clk) begin
				if ((eng_r == ST_EXEC) && op_r == OP_NVB_ERASE) begin
					nvb[gi] <= NVB_ERASED;
				end else if ((eng_r == ST_EXEC) && op_r == OP_NVB_WRITE
					&& flash_addr_r[1:0] == 2'(gi)) begin
					nvb[gi] <= flash_dlo_r[NVB_W-1:0];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Flash interface registers
	// ----------------------------------------------------------------
	// Engine results win over a bus write in the same cycle, since a
	// bus write during busy is already a misuse by the application.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flash_addr_r <= '0;
			flash_dlo_r <= '0;
			flash_dhi_r <= '0;
		end else if (cmd_go) begin
			flash_addr_r <= cmd_addr;
			flash_dlo_r <= cmd_data[15:0];
			flash_dhi_r <= cmd_data[23:16];
		end else if (eng_r == ST_READ) begin
			flash_dlo_r <= flash_rdb[15:0];
			flash_dhi_r <= flash_rdb[23:16];
		end else if ((eng_r == ST_EXEC) && op_r == OP_NVB_READ) begin
			flash_dlo_r <= {8'h00, nvb[flash_addr_r[1:0]]};
		end else if (dm_wr && dm_is_addr) begin
			flash_addr_r <= dm_req.wdata[11:0];
		end else if (dm_wr && dm_is_dlo) begin
			flash_dlo_r <= dm_req.wdata;
		end else if (dm_wr && dm_is_dhi) begin
			flash_dhi_r <= dm_req.wdata[7:0];
		end
	end

	// Done is sticky; a completion in the clearing cycle wins.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			done_r <= 1'b0;
		end else if (finish) begin
			done_r <= 1'b1;
		end else if (dm_wr && dm_is_ctrl) begin
			done_r <= 1'b0;
		end
	end

	// Control register read view.
	wire [15:0] ctrl_view = {9'h000, boot_code_r, done_r, !idle,
		1'b0, op_r};

	// ----------------------------------------------------------------
	// Utility answers
	// ----------------------------------------------------------------
	// A command offered while the code is set is dropped and flagged.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			util_refused <= 1'b0;
			util_done <= 1'b0;
			util_rdata <= '0;
		end else begin
			util_refused <= util_req.valid && boot_code_r;
			util_done <= finish && from_util_r;
			if (eng_r == ST_READ && from_util_r) begin
				util_rdata <= flash_rdb;
			end else if ((eng_r == ST_EXEC) && op_r == OP_NVB_READ
				&& from_util_r) begin
				util_rdata <= {16'h0000, nvb[flash_addr_r[1:0]]};
			end
		end
	end

	// ----------------------------------------------------------------
	// User RAMs and read data
	// ----------------------------------------------------------------
	logic [23:0] pm_ram [RAM_DEPTH]; // Program RAM with vectors.
	logic [15:0] dm_ram [RAM_DEPTH]; // User data RAM.
	logic [23:0] pm_q_r; // Non-flash program read data.
	logic pm_flash_r; // Last program read was from flash.
	logic [15:0] dm_q_r; // Data read data.

	// RAM writes; reserved and ROM writes simply fall away.
	always_ff @(posedge sys_clk) begin
		if (pm_ram_wr) begin
			pm_ram[pm_ram_idx] <= pm_req.wdata;
		end
		if (dm_ram_wr) begin
			dm_ram[dm_ram_idx] <= dm_req.wdata;
		end
	end

	// Program read: RAM, ROM pass-through, flash, else zero.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pm_q_r <= '0;
			pm_flash_r <= 1'b0;
		end else begin
			pm_flash_r <= pm_req.en && pm_in_flash;
			if (pm_ram_hit) begin
				pm_q_r <= pm_ram[pm_ram_idx];
			end else if (rom_sel) begin
				pm_q_r <= rom_rdata;
			end else begin
				pm_q_r <= '0;
			end
		end
	end
	assign pm_rdata = pm_flash_r ? flash_rda : pm_q_r;

	// Data read: RAM, flash registers, peripherals, else zero.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dm_q_r <= '0;
		end else if (dm_req.en && dm_in_ram) begin
			dm_q_r <= dm_ram[dm_ram_idx];
		end else if (dm_req.en && dm_is_ctrl) begin
			dm_q_r <= ctrl_view;
		end else if (dm_req.en && dm_is_addr) begin
			dm_q_r <= {4'h0, flash_addr_r};
		end else if (dm_req.en && dm_is_dlo) begin
			dm_q_r <= flash_dlo_r;
		end else if (dm_req.en && dm_is_dhi) begin
			dm_q_r <= {8'h00, flash_dhi_r};
		end else if (periph_sel) begin
			dm_q_r <= periph_rdata;
		end else begin
			dm_q_r <= '0;
		end
	end
	assign dm_rdata = dm_q_r;

	// ----------------------------------------------------------------
	// Boot sequencer
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		BS_INIT = 3'b001,
		BS_CHECK = 3'b010,
		BS_RUN = 3'b100
	} fbm_boot_e;

	fbm_boot_e boot_st_r; // Boot sequence state.

	// Reset holds the core in its init state and aims fetch at ROM;
	// the monitor step then picks flash or external boot.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			boot_st_r <= BS_INIT;
			fetch_load <= 1'b1;
			fetch_addr <= ROM_ENTRY;
			ext_boot_req <= 1'b0;
			core_init <= '1;
		end else begin
			fetch_load <= 1'b0;
			ext_boot_req <= 1'b0;
			unique case (boot_st_r)
				BS_INIT: begin
					core_init <= '0;
					boot_st_r <= BS_CHECK;
				end
				BS_CHECK: begin
					if (boot_code_r) begin
						fetch_load <= 1'b1;
						fetch_addr <= APP_ENTRY;
					end else begin
						ext_boot_req <= 1'b1;
					end
					boot_st_r <= BS_RUN;
				end
				BS_RUN: begin
					boot_st_r <= BS_RUN;
				end
			endcase
		end
	end

endmodule : fbm_memory_map

//--- hdl/fbm_pkg.sv
// Constants and types shared by the flash boot memory map block.
package fbm_pkg;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 14;
	localparam logic [13:0] PM_VEC_HI = 14'h002f;
	localparam logic [13:0] PM_RAM_HI = 14'h01ff;
	localparam logic [13:0] PM_ROM_LO = 14'h0800;
	localparam logic [13:0] PM_ROM_HI = 14'h17ff;
	localparam logic [13:0] PM_FL_LO = 14'h2000;
	localparam logic [13:0] PM_FL_HI = 14'h2fff;
	localparam logic [13:0] DM_PER0_LO = 14'h2000;
	localparam logic [13:0] DM_PER0_HI = 14'h20ff;
	localparam logic [13:0] DM_RAM_LO = 14'h3800;
	localparam logic [13:0] DM_RAM_HI = 14'h39ff;
	localparam logic [13:0] DM_PER1_LO = 14'h3c00;
	localparam logic [13:0] DM_PER1_HI = 14'h3fff;

	// ----------------------------------------------------------------
	// Flash array and sectors (indices are offsets from PM_FL_LO)
	// ----------------------------------------------------------------
	localparam int FLASH_WORDS = 4096;
	localparam int FLASH_W = 24;
	localparam int FLASH_AW = 12;
	localparam logic [11:0] SEC1_IDX = 12'h100;
	localparam logic [11:0] SEC2_IDX = 12'h200;
	localparam logic [11:0] SEC0_LAST = 12'h0ff;
	localparam logic [11:0] SEC1_LAST = 12'h1ff;
	localparam logic [11:0] SEC2_LAST = 12'hfff;
	localparam logic [23:0] FLASH_ERASED = 24'h000000;
	localparam int RAM_WORDS = 512;

	// ----------------------------------------------------------------
	// Nonvolatile byte registers
	// ----------------------------------------------------------------
	localparam int NVB_COUNT = 4;
	localparam int NVB_W = 8;
	localparam logic [7:0] NVB_ERASED = 8'h00;

	// ----------------------------------------------------------------
	// Flash interface registers and control fields
	// ----------------------------------------------------------------
	localparam logic [13:0] REG_FLASH_CTRL = 14'h2080;
	localparam logic [13:0] REG_FLASH_ADDR = 14'h2081;
	localparam logic [13:0] REG_FLASH_DLO = 14'h2082;
	localparam logic [13:0] REG_FLASH_DHI = 14'h2083;
	localparam int CTL_OP_LSB = 0;
	localparam int CTL_GO = 3;
	localparam int CTL_BUSY = 4;
	localparam int CTL_DONE = 5;
	localparam int CTL_BOOT = 6;

	// ----------------------------------------------------------------
	// Boot vectors
	// ----------------------------------------------------------------
	localparam logic [13:0] ROM_ENTRY = 14'h0800;
	localparam logic [13:0] APP_ENTRY = 14'h2200;

	// Flash engine operations.
	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_PROGRAM = 3'h1,
		OP_ERASE_SECTOR = 3'h2,
		OP_ERASE_ALL = 3'h3,
		OP_NVB_READ = 3'h4,
		OP_NVB_WRITE = 3'h5,
		OP_NVB_ERASE = 3'h6,
		OP_SET_BOOT = 3'h7
	} fbm_op_e;

	// Program memory request from the core.
	typedef struct packed {
		logic en;
		logic we;
		logic [13:0] addr;
		logic [23:0] wdata;
	} fbm_pm_req_s;

	// Data memory request from the core.
	typedef struct packed {
		logic en;
		logic we;
		logic [13:0] addr;
		logic [15:0] wdata;
	} fbm_dm_req_s;

	// Command from the external programming utility.
	typedef struct packed {
		logic valid;
		fbm_op_e op;
		logic [11:0] addr;
		logic [23:0] data;
	} fbm_util_req_s;

	// Reset actions handed to the core.
	typedef struct packed {
		logic stack_empty;
		logic irq_mask_all;
		logic mode_status_clear;
	} fbm_core_init_s;

endpackage : fbm_pkg
